/* File: asr_pkg.sv */
// Package of constants and types for the asynchronous static RAM controller.
package asr_pkg;
   localparam int unsigned ASR_CLK_PERIOD_NS = 50;
   localparam int unsigned ASR_ADDR_W = 18;
   localparam int unsigned ASR_DATA_W = 16;
   localparam int unsigned ASR_LANE_W = 8;
   localparam int unsigned ASR_LOW_LANE_LSB = 0;
   localparam int unsigned ASR_UP_LANE_LSB = 8;
   localparam int unsigned ASR_CNT_W = 4;
   // Timing figures in nanoseconds.
   localparam int unsigned READ_CYCLE_MIN_NS = 12;
   localparam int unsigned WRITE_CYCLE_MIN_NS = 12;
   localparam int unsigned ADDRESS_ACCESS_MAX_NS = 12;
   localparam int unsigned SELECT_ACCESS_MAX_NS = 12;
   localparam int unsigned OUTPUT_HIGHZ_MAX_NS = 6;
   localparam int unsigned WRITE_PULSE_MIN_NS = 8;
   localparam int unsigned ADDRESS_SETUP_MIN_NS = 0;
   localparam int unsigned WRITE_RECOVERY_MIN_NS = 0;
   localparam int unsigned DATA_SETUP_MIN_NS = 6;
   localparam int unsigned DATA_HOLD_MIN_NS = 0;
   // Cycle counts: least times round up, at least one cycle each.
   localparam int unsigned ASR_ACCESS_CYC_I =
      (ADDRESS_ACCESS_MAX_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
   localparam int unsigned ASR_PULSE_CYC_I =
      (WRITE_PULSE_MIN_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
   localparam int unsigned ASR_TURN_CYC_I =
      (OUTPUT_HIGHZ_MAX_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
   // Two cycles are added to access: the data pins pass a synchroniser.
   localparam logic [ASR_CNT_W-1:0] ASR_READ_CYC =
      ASR_CNT_W'((ASR_ACCESS_CYC_I < 1 ? 1 : ASR_ACCESS_CYC_I) + 2);
   localparam logic [ASR_CNT_W-1:0] ASR_WRITE_CYC =
      ASR_CNT_W'(ASR_PULSE_CYC_I < 1 ? 1 : ASR_PULSE_CYC_I);
   localparam logic [ASR_CNT_W-1:0] ASR_TURN_CYC =
      ASR_CNT_W'(ASR_TURN_CYC_I < 1 ? 1 : ASR_TURN_CYC_I);
   localparam logic [ASR_ADDR_W-1:0] ASR_ADDR_RST = 18'h00000;
   localparam logic [ASR_DATA_W-1:0] ASR_DATA_RST = 16'h0000;
   typedef enum logic [2:0] {
      ASR_IDLE, ASR_SETUP, ASR_RD, ASR_WR, ASR_REC
   } asr_state_e;
endpackage

/* File: asr_sync.sv */
// Two-flop synchroniser for a bus of pin inputs.
`timescale 1ns/1ns
module asr_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Pin side and synchronised side.
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } asr_sync_s;
   asr_sync_s st_r;
   asr_sync_s st_nxt;

   always_comb begin
      st_nxt.meta = i_async;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_sync = st_r.sync;
endmodule

/* File: asr_ctrl.sv */
// Controller that drives an asynchronous 256K x 16 static RAM over its pins.
`timescale 1ns/1ns
module asr_ctrl
   import asr_pkg::*;
(
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // User request.
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire logic i_req_write,
   input wire logic [ASR_ADDR_W-1:0] i_req_addr,
   input wire logic [ASR_DATA_W-1:0] i_req_wdata,
   input wire logic [1:0] i_req_lane_en,
   // Read answer.
   output logic o_rsp_valid,
   output logic [ASR_DATA_W-1:0] o_rsp_rdata,
   // Memory pins.
   output logic [ASR_ADDR_W-1:0] o_word_address_bus,
   output logic o_chip_select_low,
   output logic o_output_enable_low,
   output logic o_write_enable_low,
   output logic o_lower_lane_select_low,
   output logic o_upper_lane_select_low,
   input wire logic [ASR_DATA_W-1:0] i_bidir_data_bus,
   output logic [ASR_DATA_W-1:0] o_bidir_data_bus,
   output logic o_bidir_data_bus_oe
);
   typedef struct packed {
      asr_state_e state;
      logic [ASR_CNT_W-1:0] cnt;
      logic write;
      logic [ASR_ADDR_W-1:0] addr;
      logic [ASR_DATA_W-1:0] wdata;
      logic cs_n;
      logic oe_n;
      logic we_n;
      logic lb_n;
      logic ub_n;
      logic data_oe;
      logic rsp_valid;
      logic [ASR_DATA_W-1:0] rdata;
   } asr_ctrl_s;

   asr_ctrl_s st_r;
   asr_ctrl_s st_nxt;
   logic [ASR_DATA_W-1:0] data_sync;
   logic [ASR_DATA_W-1:0] lane_keep;
   logic [ASR_DATA_W-1:0] rd_masked;

   asr_sync #(.WIDTH(ASR_DATA_W)) u_data_sync (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_async(i_bidir_data_bus),
      .o_sync(data_sync)
   );

   // Lanes left unselected float at the pins, so their bits are cleared
   // rather than handed on as whatever the bus happened to show.
   always_comb begin
      lane_keep = '0;
      if (!st_r.lb_n) begin
         lane_keep[ASR_LOW_LANE_LSB +: ASR_LANE_W] = {ASR_LANE_W{1'b1}};
      end
      if (!st_r.ub_n) begin
         lane_keep[ASR_UP_LANE_LSB +: ASR_LANE_W] = {ASR_LANE_W{1'b1}};
      end
      rd_masked = data_sync & lane_keep;
   end

   // An access runs IDLE, SETUP, then RD or WR, then REC. Address and lane
   // selects are set one cycle before the strobes fall and kept one cycle
   // after they rise, which covers set-up, recovery and data hold.
   // A read answer follows the take by five cycles; a write takes four.
   always_comb begin
      st_nxt = st_r;
      st_nxt.rsp_valid = 1'b0;
      case (st_r.state)
         ASR_IDLE: begin
            // Strobes stay high here, so the address may move.
            st_nxt.cs_n = 1'b1;
            st_nxt.oe_n = 1'b1;
            st_nxt.we_n = 1'b1;
            st_nxt.data_oe = 1'b0;
            if (i_req_valid) begin
               st_nxt.addr = i_req_addr;
               st_nxt.write = i_req_write;
               st_nxt.wdata = i_req_wdata;
               st_nxt.lb_n = ~i_req_lane_en[0];
               st_nxt.ub_n = ~i_req_lane_en[1];
               st_nxt.state = ASR_SETUP;
            end
         end

         ASR_SETUP: begin
            // Address has stood one full cycle before any strobe falls.
            st_nxt.cs_n = 1'b0;
            if (st_r.write) begin
               // Write low with the selects keeps the memory floating.
               st_nxt.we_n = 1'b0;
               st_nxt.oe_n = 1'b1;
               // Memory is floating, so the bus is ours.
               st_nxt.data_oe = 1'b1;
               st_nxt.cnt = ASR_WRITE_CYC;
               st_nxt.state = ASR_WR;
            end else begin
               // Strobes stay low for access plus the synchroniser depth.
               st_nxt.oe_n = 1'b0;
               st_nxt.data_oe = 1'b0;
               st_nxt.cnt = ASR_READ_CYC;
               st_nxt.state = ASR_RD;
            end
         end

         ASR_RD: begin
            if (st_r.cnt == ASR_CNT_W'(1)) begin
               // Capture while address and strobes still stand.
               st_nxt.rdata = rd_masked;
               st_nxt.rsp_valid = 1'b1;
               st_nxt.cs_n = 1'b1;
               st_nxt.oe_n = 1'b1;
               st_nxt.cnt = ASR_TURN_CYC;
               st_nxt.state = ASR_REC;
            end else begin
               st_nxt.cnt = st_r.cnt - ASR_CNT_W'(1);
            end
         end

         ASR_WR: begin
            // A pulse of one whole clock is far above the least width.
            if (st_r.cnt == ASR_CNT_W'(1)) begin
               // Window closes; address and data stay one more cycle.
               st_nxt.we_n = 1'b1;
               st_nxt.cs_n = 1'b1;
               st_nxt.cnt = ASR_TURN_CYC;
               st_nxt.state = ASR_REC;
            end else begin
               st_nxt.cnt = st_r.cnt - ASR_CNT_W'(1);
            end
         end

         ASR_REC: begin
            // Recovery keeps every strobe high while the bus turns round,
            // so the next address may change as soon as this state ends.
            st_nxt.cs_n = 1'b1;
            st_nxt.oe_n = 1'b1;
            st_nxt.we_n = 1'b1;
            st_nxt.data_oe = 1'b0;
            if (st_r.cnt == ASR_CNT_W'(1)) begin
               st_nxt.lb_n = 1'b1;
               st_nxt.ub_n = 1'b1;
               st_nxt.state = ASR_IDLE;
            end else begin
               st_nxt.cnt = st_r.cnt - ASR_CNT_W'(1);
            end
         end

         default: begin
            // An unknown state releases the pins and returns to idle.
            st_nxt.cs_n = 1'b1;
            st_nxt.oe_n = 1'b1;
            st_nxt.we_n = 1'b1;
            st_nxt.lb_n = 1'b1;
            st_nxt.ub_n = 1'b1;
            st_nxt.data_oe = 1'b0;
            st_nxt.state = ASR_IDLE;
         end
      endcase
   end

   // Reset puts every strobe high and releases the data pins.
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         st_r.state <= ASR_IDLE;
         st_r.cnt <= '0;
         st_r.write <= 1'b0;
         st_r.addr <= ASR_ADDR_RST;
         st_r.wdata <= ASR_DATA_RST;
         st_r.cs_n <= 1'b1;
         st_r.oe_n <= 1'b1;
         st_r.we_n <= 1'b1;
         st_r.lb_n <= 1'b1;
         st_r.ub_n <= 1'b1;
         st_r.data_oe <= 1'b0;
         st_r.rsp_valid <= 1'b0;
         st_r.rdata <= ASR_DATA_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_req_ready = (st_r.state == ASR_IDLE);
   assign o_rsp_valid = st_r.rsp_valid;
   assign o_rsp_rdata = st_r.rdata;
   assign o_word_address_bus = st_r.addr;
   assign o_chip_select_low = st_r.cs_n;
   assign o_output_enable_low = st_r.oe_n;
   assign o_write_enable_low = st_r.we_n;
   assign o_lower_lane_select_low = st_r.lb_n;
   assign o_upper_lane_select_low = st_r.ub_n;
   assign o_bidir_data_bus = st_r.wdata;
   assign o_bidir_data_bus_oe = st_r.data_oe;
endmodule

/* File: asr_ctrl_props.sv */
// Checker of pin sequencing for the static RAM controller.
`timescale 1ns/1ns
module asr_ctrl_props
   import asr_pkg::*;
(
   // Watched ports of the controller.
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_req_valid,
   input wire logic o_req_ready,
   input wire logic i_req_write,
   input wire logic [ASR_ADDR_W-1:0] i_req_addr,
   input wire logic [ASR_DATA_W-1:0] i_req_wdata,
   input wire logic [1:0] i_req_lane_en,
   input wire logic o_rsp_valid,
   input wire logic [ASR_ADDR_W-1:0] o_word_address_bus,
   input wire logic o_chip_select_low,
   input wire logic o_output_enable_low,
   input wire logic o_write_enable_low,
   input wire logic o_lower_lane_select_low,
   input wire logic o_upper_lane_select_low,
   input wire logic [ASR_DATA_W-1:0] o_bidir_data_bus,
   input wire logic o_bidir_data_bus_oe
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   wire cs_n = o_chip_select_low;
   wire we_n = o_write_enable_low;
   wire rd_take = i_req_valid && o_req_ready && !i_req_write;
   wire wr_take = i_req_valid && o_req_ready && i_req_write;
   wire [1:0] lanes_n = {o_upper_lane_select_low, o_lower_lane_select_low};
   a_addr_held_sel: assert property (
      !cs_n |-> $stable(o_word_address_bus))
      else $error("Address moved while chip was selected.");
   a_no_bus_fight: assert property (
      !cs_n && !o_output_enable_low |-> !o_bidir_data_bus_oe)
      else $error("Data driven into a read.");
   a_write_open: assert property (
      $fell(we_n) |-> !cs_n && o_bidir_data_bus_oe
      && $stable(o_bidir_data_bus))
      else $error("Write opened without chip select or stable data.");
   a_write_hold: assert property (
      $rose(we_n) |-> o_bidir_data_bus_oe
      && $stable(o_word_address_bus) && $stable(o_bidir_data_bus))
      else $error("Address or data dropped at write close.");
   a_setup_first: assert property (
      $fell(cs_n) |-> $stable(lanes_n) && $stable(o_word_address_bus))
      else $error("Set-up missing.");
   a_cycle_gap: assert property ($rose(cs_n) |=> cs_n)
      else $error("Chip reselected too soon.");
   a_read_strobes: assert property (
      rd_take |=> ##1 (!cs_n && !o_output_enable_low && we_n)
      ##1 !cs_n ##1 !cs_n)
      else $error("Read strobes wrong.");
   a_read_answer: assert property (rd_take |-> ##5 o_rsp_valid)
      else $error("Read answer late.");
   a_lane_map: assert property (
      $past(i_req_valid && o_req_ready) |->
      lanes_n == ~$past(i_req_lane_en)
      && o_word_address_bus == $past(i_req_addr))
      else $error("Lane or address mapping wrong.");
   a_write_data: assert property (
      wr_take |=> o_bidir_data_bus == $past(i_req_wdata))
      else $error("Write data wrong.");
   a_write_pulse: assert property (
      wr_take |=> ##1 (!we_n && !cs_n) ##1 we_n)
      else $error("Write pulse wrong.");
endmodule
bind asr_ctrl asr_ctrl_props u_props (
   .i_sys_clk(i_sys_clk),
   .i_reset(i_reset),
   .i_req_valid(i_req_valid),
   .o_req_ready(o_req_ready),
   .i_req_write(i_req_write),
   .i_req_addr(i_req_addr),
   .i_req_wdata(i_req_wdata),
   .i_req_lane_en(i_req_lane_en),
   .o_rsp_valid(o_rsp_valid),
   .o_word_address_bus(o_word_address_bus),
   .o_chip_select_low(o_chip_select_low),
   .o_output_enable_low(o_output_enable_low),
   .o_write_enable_low(o_write_enable_low),
   .o_lower_lane_select_low(o_lower_lane_select_low),
   .o_upper_lane_select_low(o_upper_lane_select_low),
   .o_bidir_data_bus(o_bidir_data_bus),
   .o_bidir_data_bus_oe(o_bidir_data_bus_oe)
);

/* File: asr_mem_model.sv */
// Behavioural model of the asynchronous static RAM on the pins.
`timescale 1ns/1ns
module asr_mem_model
   import asr_pkg::*;
(
   // Memory pins.
   input wire logic [ASR_ADDR_W-1:0] i_addr,
   input wire logic i_cs_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic i_lb_n,
   input wire logic i_ub_n,
   input wire logic [ASR_DATA_W-1:0] i_dq,
   output logic [ASR_DATA_W-1:0] o_dq
);
   // Two-state words read as zero until written.
   bit [ASR_DATA_W-1:0] mem [0:(1<<ASR_ADDR_W)-1];
   logic [ASR_DATA_W-1:0] last = 16'h0000;
   wire win = !i_cs_n && !i_we_n && !(i_lb_n && i_ub_n);
   wire rd_en = !i_cs_n && !i_oe_n && i_we_n;
   wire [ASR_DATA_W-1:0] rd = mem[i_addr];
   // Stores at window close; floating lanes show the inverse of last data.
   always @(negedge win) begin
      if (!i_lb_n) mem[i_addr][7:0] = i_dq[7:0];
      if (!i_ub_n) mem[i_addr][15:8] = i_dq[15:8];
   end
   always @(negedge rd_en) last = rd;
   assign #6 o_dq = {
      (rd_en && !i_ub_n) ? rd[15:8] : ~last[15:8],
      (rd_en && !i_lb_n) ? rd[7:0] : ~last[7:0]};
endmodule

/* File: tb.sv */
// Self-checking testbench for the static RAM controller.
`timescale 1ns/1ns
module tb
   import asr_pkg::*;
;
   logic i_sys_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_req_valid = 1'b0;
   logic i_req_write = 1'b0;
   logic [ASR_ADDR_W-1:0] i_req_addr = 18'h00000;
   logic [ASR_DATA_W-1:0] i_req_wdata = 16'h0000;
   logic [1:0] i_req_lane_en = 2'h0;
   logic o_req_ready, o_rsp_valid, o_bidir_data_bus_oe;
   logic o_chip_select_low, o_output_enable_low, o_write_enable_low;
   logic o_lower_lane_select_low, o_upper_lane_select_low;
   logic [ASR_ADDR_W-1:0] o_word_address_bus;
   logic [ASR_DATA_W-1:0] o_rsp_rdata, o_bidir_data_bus, mem_dq;
   wire [ASR_DATA_W-1:0] i_bidir_data_bus =
      o_bidir_data_bus_oe ? o_bidir_data_bus : mem_dq;
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   asr_ctrl uut (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_req_valid(i_req_valid),
      .o_req_ready(o_req_ready),
      .i_req_write(i_req_write),
      .i_req_addr(i_req_addr),
      .i_req_wdata(i_req_wdata),
      .i_req_lane_en(i_req_lane_en),
      .o_rsp_valid(o_rsp_valid),
      .o_rsp_rdata(o_rsp_rdata),
      .o_word_address_bus(o_word_address_bus),
      .o_chip_select_low(o_chip_select_low),
      .o_output_enable_low(o_output_enable_low),
      .o_write_enable_low(o_write_enable_low),
      .o_lower_lane_select_low(o_lower_lane_select_low),
      .o_upper_lane_select_low(o_upper_lane_select_low),
      .i_bidir_data_bus(i_bidir_data_bus),
      .o_bidir_data_bus(o_bidir_data_bus),
      .o_bidir_data_bus_oe(o_bidir_data_bus_oe)
   );
   asr_mem_model mem (.i_addr(o_word_address_bus), .i_cs_n(o_chip_select_low),
      .i_oe_n(o_output_enable_low), .i_we_n(o_write_enable_low),
      .i_lb_n(o_lower_lane_select_low), .i_ub_n(o_upper_lane_select_low),
      .i_dq(i_bidir_data_bus), .o_dq(mem_dq));
   initial forever #25 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         results();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic req(input logic wr, input logic [17:0] a,
      input logic [15:0] d, input logic [1:0] ln);
      i_req_valid <= 1'b1;
      i_req_write <= wr;
      i_req_addr <= a;
      i_req_wdata <= d;
      i_req_lane_en <= ln;
      do @(posedge i_sys_clk); while (o_req_ready !== 1'b1);
      i_req_valid <= 1'b0;
      // One edge passes so a following request never rewrites valid here.
      @(posedge i_sys_clk);
   endtask
   task automatic rd(input logic [17:0] a, input logic [1:0] ln,
      input logic [15:0] exp, input logic [15:0] mask);
      req(1'b0, a, 16'h0000, ln);
      for (int i = 0; i < 8 && o_rsp_valid !== 1'b1; i++) begin
         @(posedge i_sys_clk);
      end
      chk({15'h0000, o_rsp_valid}, 16'h0001);
      chk(o_rsp_rdata & mask, exp & mask);
   endtask
   task automatic t_reset();
      chk({9'h000, o_bidir_data_bus_oe, o_req_ready, o_chip_select_low,
         o_output_enable_low, o_write_enable_low, o_upper_lane_select_low,
         o_lower_lane_select_low}, 16'h003f);
      $display("test reset done");
   endtask
   task automatic t_full();
      req(1'b1, 18'h3ffff, 16'ha55a, 2'h3);
      rd(18'h3ffff, 2'h3, 16'ha55a, 16'hffff);
      $display("test full word done");
   endtask
   task automatic t_lanes();
      req(1'b1, 18'h00001, 16'h1234, 2'h3);
      req(1'b1, 18'h00001, 16'hab00, 2'h2);
      req(1'b1, 18'h00001, 16'h00cd, 2'h0);
      rd(18'h00001, 2'h3, 16'hab34, 16'hffff);
      rd(18'h00001, 2'h1, 16'h0034, 16'hffff);
      $display("test lanes done");
   endtask
   task automatic results();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      t_reset();
      t_full();
      t_lanes();
      results();
   end
endmodule
